// ==== core/return_and_rotate_carry_exec.v ====
// Summary of operation
// - decode return as 0000 0000 0001 001s
// - return pops stack, top loads program counter
// - shadow bit one restores accumulator, flags, bank
// - shadow bit zero leaves those registers alone
// - rotate left, carry in bit0, bit7 out
// - destination bit zero writes accumulator, else file
// - access bit zero selects access bank
// - return with literal loads accumulator and pops
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "ret_rot_consts.vh"
module return_and_rotate_carry_exec #(
  parameter PC_W = 21
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  // instruction issue, one word per instruction cycle
  input wire instr_valid,
  input wire [15:0] instr,
  // return stack side
  input wire [PC_W-1:0] top_of_return_stack,
  output wire stack_pop,
  // file register port
  output reg [11:0] file_addr,
  input wire [7:0] file_rdata,
  output reg file_we,
  output reg [7:0] file_wdata,
  // shadow copies
  input wire [7:0] accumulator_shadow,
  input wire [7:0] flags_shadow,
  input wire [3:0] bank_pointer_shadow,
  // live core state
  output reg [PC_W-1:0] pc,
  output reg [7:0] accumulator,
  output reg [7:0] flags,
  output reg [3:0] bank_select_register,
  output reg [7:0] pc_upper_latch,
  output reg [7:0] pc_high_latch,
  output wire busy
);

  // instruction classes held for the length of one instruction
  localparam K_NONE = 2'b00;
  localparam K_RET = 2'b01;
  localparam K_RETLIT = 2'b10;
  localparam K_ROTC = 2'b11;

  // quarter phase of the current instruction cycle
  reg [1:0] phase;
  // high through q1 of the idle cycle that follows a return
  reg second_cycle;
  // class of the word being executed, none when idle
  reg [1:0] instr_kind;
  // copy of the word being executed, its fields are read in q4
  reg [15:0] cur;
  // file register value fetched in q2 for the rotate
  reg [7:0] operand;

  // classify an instruction word
  function [1:0] decode;
    input [15:0] w;
    begin
      if (w[`OP_MSB:`RETURN_OP_LSB] == `RETURN_OP_TOP)
        decode = K_RET;
      else if (w[`OP_MSB:`RETLIT_OP_LSB] == `RETLIT_OP_TOP)
        decode = K_RETLIT;
      else if (w[`OP_MSB:`ROTC_OP_LSB] == `ROTC_OP_TOP)
        decode = K_ROTC;
      else
        decode = K_NONE;
    end
  endfunction

  // both kinds of return pop the stack and add an idle cycle
  function is_return;
    input [1:0] kind;
    begin
      is_return = (kind == K_RET) || (kind == K_RETLIT);
    end
  endfunction

  // phase decodes
  wire in_q1 = (phase == `PH_Q1);
  wire in_q2 = (phase == `PH_Q2);
  wire in_q4 = (phase == `PH_Q4);

  // a word is taken only in q1 of a fresh instruction cycle
  wire take = instr_valid && in_q1 && !second_cycle;

  // file address of the offered word, access bank or banked
  // the access bank splits on the top address bit: low half of
  // bank zero below it, top half of the last bank above it
  wire [11:0] access_addr = {{`BANK_W{instr[`SIGN_BIT]}},
                             instr[`FILE_MSB:`FILE_LSB]};
  wire [11:0] banked_addr = {bank_select_register,
                             instr[`FILE_MSB:`FILE_LSB]};

  // fields of the captured word
  wire shadow_sel = cur[`SHADOW_BIT];
  wire dest_file = cur[`DEST_BIT];
  wire [7:0] literal = cur[`LIT_MSB:`LIT_LSB];

  // rotate-through-carry result and carry out
  wire [7:0] rot_result = {operand[`SIGN_BIT-1:0], flags[`FLAG_C]};
  wire rot_carry = operand[`SIGN_BIT];
  wire rot_zero = (rot_result == `ZERO_BYTE);

  // pop in q4 of a return; the idle cycle holds no class
  assign stack_pop = is_return(instr_kind) && in_q4;
  // returns take two instruction cycles, the second a no-operation
  assign busy = second_cycle || !in_q1;

  // four phase sequencer; q1 waits until a word is taken, except in the idle cycle after a return
  always @(posedge clock) begin
    if (!rstn) begin
      phase <= `PH_Q1;
    end else begin
      case (phase)
        `PH_Q1: begin
          if (take || second_cycle)
            phase <= `PH_Q2;
        end
        `PH_Q2: phase <= `PH_Q3;
        `PH_Q3: phase <= `PH_Q4;
        `PH_Q4: phase <= `PH_Q1;
        default: phase <= `PH_Q1;
      endcase
    end
  end

  // idle cycle marker: set by q4 of a return, cleared in its q1
  // q2..q4 of the idle cycle are kept busy by the phase alone
  always @(posedge clock) begin
    if (!rstn) begin
      second_cycle <= 1'b0;
    end else if (in_q4 && is_return(instr_kind)) begin
      second_cycle <= 1'b1;
    end else if (in_q1) begin
      second_cycle <= 1'b0;
    end
  end

  // capture the word and form the file address at the taking edge
  // any other q1 clears the class, so an idle or no-operation
  // cycle can never repeat the previous instruction's work
  always @(posedge clock) begin
    if (!rstn) begin
      cur <= `RESET_WORD;
      instr_kind <= K_NONE;
      file_addr <= `RESET_ADDR;
    end else if (in_q1) begin
      if (take) begin
        cur <= instr;
        instr_kind <= decode(instr);
        if (instr[`ACCESS_BIT] == 1'b0)
          file_addr <= access_addr;
        else
          file_addr <= banked_addr;
      end else begin
        instr_kind <= K_NONE;
      end
    end
  end

  // file register operand is read in q2 of a rotate
  always @(posedge clock) begin
    if (!rstn) begin
      operand <= `RESET_BYTE;
    end else if (in_q2 && (instr_kind == K_ROTC)) begin
      operand <= file_rdata;
    end
  end

  // q4 write back: program counter, accumulator, flags, bank
  // the file write strobe is a single cycle after that edge
  always @(posedge clock) begin
    if (!rstn) begin
      file_we <= 1'b0;
      file_wdata <= `RESET_BYTE;
      pc <= {PC_W{1'b0}};
      accumulator <= `RESET_BYTE;
      flags <= `RESET_BYTE;
      bank_select_register <= `RESET_BANK;
    end else begin
      file_we <= 1'b0;
      if (in_q4) begin
        case (instr_kind)
          K_RET: begin
            pc <= top_of_return_stack;
            if (shadow_sel) begin
              accumulator <= accumulator_shadow;
              flags <= flags_shadow;
              bank_select_register <= bank_pointer_shadow;
            end
            // shadow bit clear: registers hold
          end
          K_RETLIT: begin
            accumulator <= literal;
            pc <= top_of_return_stack;
          end
          K_ROTC: begin
            if (dest_file == 1'b0) begin
              accumulator <= rot_result;
            end else begin
              file_we <= 1'b1;
              file_wdata <= rot_result;
            end
            // only c, n and z move; other flag bits are kept
            flags[`FLAG_C] <= rot_carry;
            flags[`FLAG_N] <= rot_result[`SIGN_BIT];
            flags[`FLAG_Z] <= rot_zero;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // program counter latches: only reset writes them,
  // so a return leaves them at the zero that reset loaded
  always @(posedge clock) begin
    if (!rstn) begin
      pc_upper_latch <= `RESET_BYTE;
      pc_high_latch <= `RESET_BYTE;
    end
  end

endmodule

// ==== pkg/ret_rot_consts.vh ====
`ifndef RET_ROT_CONSTS_VH
`define RET_ROT_CONSTS_VH
// opcode patterns (upper bits compared against the instruction word)
`define RETURN_OP_TOP    15'h0009
`define RETLIT_OP_TOP    8'h0c
`define ROTC_OP_TOP      6'h0d
// lowest instruction bit that each opcode pattern covers
`define RETURN_OP_LSB    1
`define RETLIT_OP_LSB    8
`define ROTC_OP_LSB      10
`define OP_MSB           15
// instruction field positions
`define SHADOW_BIT       0
`define DEST_BIT         9
`define ACCESS_BIT       8
`define LIT_MSB          7
`define LIT_LSB          0
`define FILE_MSB         7
`define FILE_LSB         0
// top bit of a data byte, also the access bank split bit
`define SIGN_BIT         7
`define ZERO_BYTE        8'h00
// status register bit positions
`define FLAG_C           0
`define FLAG_Z           2
`define FLAG_N           4
// quarter phase codes
`define PH_Q1            2'h0
`define PH_Q2            2'h1
`define PH_Q3            2'h2
`define PH_Q4            2'h3
// reset values and bank field width
`define RESET_BYTE       8'h00
`define RESET_WORD       16'h0000
`define RESET_ADDR       12'h000
`define RESET_BANK       4'h0
`define BANK_W           4
`endif

// ==== sim/ret_rot_sva.sv ====
`timescale 1ns/1ns
module ret_rot_sva (
  // clock, reset, issue
  input wire clock,
  input wire rstn,
  input wire instr_valid,
  input wire [15:0] instr,
  input wire busy,
  // results
  input wire stack_pop,
  input wire [20:0] top_of_return_stack,
  input wire [20:0] pc,
  input wire file_we,
  input wire [7:0] accumulator,
  input wire [7:0] pc_upper_latch,
  input wire [7:0] pc_high_latch
);
  // words taken at a q1 edge
  wire ret = instr_valid && !busy && instr[15:1] == 15'h0009;
  wire rot = instr_valid && !busy && instr[15:10] == 6'h0d;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_ret_pops: assert property (ret |-> ##3 stack_pop)
    else $error("no pop");
  a_pop_load: assert property (
    stack_pop |=> pc == $past(top_of_return_stack)) else $error("bad pc");
  a_ret_busy: assert property (ret |=> busy [*7])
    else $error("short return");
  a_pop_busy: assert property (stack_pop |-> busy)
    else $error("pop when idle");
  a_keep_acc: assert property (
    ret && !instr[0] |-> ##4 $stable(accumulator)) else $error("acc moved");
  a_rot_file: assert property (rot && instr[9] |-> ##4 file_we)
    else $error("no write");
  a_rot_acc: assert property (rot && !instr[9] |-> ##4 !file_we)
    else $error("stray write");
  a_latch_kept: assert property (
    $stable({pc_upper_latch, pc_high_latch})) else $error("latch moved");
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic clock = 0, rstn = 0, instr_valid = 0;
  logic [15:0] instr = 16'h0000;
  logic [20:0] top_of_return_stack = 21'h00000;
  logic popped = 1'b0;
  logic [7:0] file_rdata = 8'h00, accumulator_shadow = 8'h5a;
  logic [7:0] flags_shadow = 8'h01;
  logic [3:0] bank_pointer_shadow = 4'h3;
  wire stack_pop, file_we, busy;
  wire [11:0] file_addr;
  wire [7:0] file_wdata, accumulator, flags, pc_upper_latch, pc_high_latch;
  wire [3:0] bank_select_register;
  wire [20:0] pc;
  int num_errors = 0, comparisons = 0;
  return_and_rotate_carry_exec u_return_and_rotate_carry_exec (
    .clock(clock),
    .rstn(rstn),
    .instr_valid(instr_valid),
    .instr(instr),
    .top_of_return_stack(top_of_return_stack),
    .stack_pop(stack_pop),
    .file_addr(file_addr),
    .file_rdata(file_rdata),
    .file_we(file_we),
    .file_wdata(file_wdata),
    .accumulator_shadow(accumulator_shadow),
    .flags_shadow(flags_shadow),
    .bank_pointer_shadow(bank_pointer_shadow),
    .pc(pc),
    .accumulator(accumulator),
    .flags(flags),
    .bank_select_register(bank_select_register),
    .pc_upper_latch(pc_upper_latch),
    .pc_high_latch(pc_high_latch),
    .busy(busy)
  );
  // free running clock
  always #5 clock = ~clock;
  // count a comparison, report a miss
  task chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t miss", $time);
    end
  endtask
  // offer a word until taken, return once results land
  task go(input logic [15:0] w, input logic [20:0] t, input logic [7:0] d);
    @(posedge clock);
    instr <= w;
    top_of_return_stack <= t;
    file_rdata <= d;
    instr_valid <= 1'b1;
    #1;
    while (busy !== 1'b0) begin
      @(posedge clock);
      #1;
    end
    // the next edge takes the word
    @(posedge clock);
    instr_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    popped = stack_pop;
    @(posedge clock);
    #1;
  endtask
  // return, shadow copy only with s set
  task ret_scn(input logic s);
    go({15'h0009, s}, s ? 21'h00246 : 21'h1abcd, 8'h00);
    chk(pc === (s ? 21'h00246 : 21'h1abcd));
    chk(popped === 1'b1 && busy === 1'b1);
    chk(accumulator === (s ? 8'h5a : 8'h00));
    chk(bank_select_register === {2'h0, s, s} && flags === {7'h00, s});
  endtask
  // banked file rotate, carry in set
  task rot_file;
    go(16'h3712, 21'h000000, 8'he6);
    chk(file_we === 1'b1 && file_wdata === 8'hcd);
    chk(flags === 8'h11 && file_addr === 12'h312);
    chk(popped === 1'b0 && busy === 1'b0);
  endtask
  // access bank rotate into accumulator
  task rot_acc;
    go(16'h3485, 21'h000000, 8'h80);
    chk(file_we === 1'b0 && accumulator === 8'h01);
    chk(flags === 8'h01 && file_addr === 12'hf85);
  endtask
  // literal return
  task lit_scn;
    go(16'h0c3c, 21'h1f00e, 8'h00);
    chk(accumulator === 8'h3c && pc === 21'h1f00e);
    chk(popped === 1'b1 && busy === 1'b1);
    chk(pc_upper_latch === 8'h00 && pc_high_latch === 8'h00);
  endtask
  // verdict
  task finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    ret_scn(1'b0);
    ret_scn(1'b1);
    rot_file;
    rot_acc;
    lit_scn;
    finish_test;
  end
  // watchdog
  initial begin
    #5000;
    num_errors++;
    finish_test;
  end
endmodule
bind return_and_rotate_carry_exec ret_rot_sva u_ret_rot_sva (
  .clock(clock),
  .rstn(rstn),
  .instr_valid(instr_valid),
  .instr(instr),
  .busy(busy),
  .stack_pop(stack_pop),
  .top_of_return_stack(top_of_return_stack),
  .pc(pc),
  .file_we(file_we),
  .accumulator(accumulator),
  .pc_upper_latch(pc_upper_latch),
  .pc_high_latch(pc_high_latch)
);
